// ===== core/pcimon_defs.svh
`ifndef PCIMON_DEFS_SVH
`define PCIMON_DEFS_SVH

// Timeout counts in core clock cycles, counted from the start edge
`define PCIMON_CNT_W        5
`define PCIMON_MABORT_CLKS  5'h04
`define PCIMON_NORESP_CLKS  5'h10

// Sequence width and reset values
`define PCIMON_SEQ_W        16
`define PCIMON_SEQ_RST      16'h0000
`define PCIMON_AGE_RST      5'h00
`define PCIMON_CNT_RST      5'h00

`endif

// ===== core/pcimon_pkg.sv
package pcimon_pkg;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_BUSY  = 3'b010,
      ST_DRAIN = 3'b100
   } pcimon_state_t;

   typedef enum logic [3:0] {
      MSG_NONE   = 4'h0,
      MSG_START  = 4'h1,
      MSG_RETRY  = 4'h2,
      MSG_TABORT = 4'h3,
      MSG_DISC_A = 4'h4,
      MSG_DISC_B = 4'h5,
      MSG_MABORT = 4'h6,
      MSG_NORESP = 4'h7,
      MSG_DONE   = 4'h8
   } pcimon_msg_t;

endpackage

// ===== core/pcimon_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcimon_defs.svh"

module pcimon_timer #(
   parameter int unsigned        CNT_W = `PCIMON_CNT_W,
   parameter logic [CNT_W-1:0]   LIMIT = `PCIMON_NORESP_CLKS
) (
   // Clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_nrst,
   // Control
   input  wire logic i_start,
   input  wire logic i_resp,
   input  wire logic i_clear,
   // Result
   output logic      o_expired
);

   localparam logic [CNT_W-1:0] LAST = LIMIT - 1'b1;

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic             run_reg;
   logic             run_next;
   logic             exp_reg;
   logic             exp_next;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      cnt_next = cnt_reg;
      run_next = run_reg;
      exp_next = 1'b0;
      if (i_start) begin
         cnt_next = '0;
         run_next = 1'b1;
      end else if (i_clear) begin
         run_next = 1'b0;
      end else if (run_reg) begin
         if (i_resp) begin
            run_next = 1'b0;
         end else if (cnt_reg == LAST) begin
            exp_next = 1'b1;
            run_next = 1'b0;
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_reg <= `PCIMON_CNT_RST;
         run_reg <= 1'b0;
         exp_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         run_reg <= run_next;
         exp_reg <= exp_next;
      end
   end

   assign o_expired = exp_reg;

   ////////////////////////////////////////////////////////////////////////////
   chk_resp_stops_timer: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      (run_reg && i_resp && !i_start) |=> !o_expired [*2])
      else $error("timer expired after response was seen");

endmodule

`default_nettype wire

// ===== core/pcimon_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcimon_defs.svh"

module pcimon_top #(
   parameter logic [`PCIMON_CNT_W-1:0] MABORT_CLKS = `PCIMON_MABORT_CLKS,
   parameter logic [`PCIMON_CNT_W-1:0] NORESP_CLKS = `PCIMON_NORESP_CLKS
) (
   // Clock and reset
   input  wire logic                   i_core_clk,
   input  wire logic                   i_nrst,
   // Bus lines, all active low
   input  wire logic                   i_framen,
   input  wire logic                   i_irdyn,
   input  wire logic                   i_trdyn,
   input  wire logic                   i_devseln,
   input  wire logic                   i_stopn,
   // Console report
   output logic                        o_console_valid,
   output pcimon_pkg::pcimon_msg_t     o_console_msg,
   // Log report
   output logic                        o_log_valid,
   output pcimon_pkg::pcimon_msg_t     o_log_msg,
   output logic [`PCIMON_SEQ_W-1:0]    o_log_seq,
   // Status to master transactor
   output logic                        o_mstr_status_valid,
   output pcimon_pkg::pcimon_msg_t     o_mstr_status,
   output logic                        o_busy
);
   import pcimon_pkg::*;

   logic [4:0]              sync1_reg;
   logic [4:0]              sync2_reg;
   logic                    frame_a;
   logic                    irdy_a;
   logic                    trdy_a;
   logic                    devsel_a;
   logic                    stop_a;

   pcimon_state_t           st_reg;
   pcimon_state_t           st_next;
   logic                    fprev_reg;
   logic                    data_reg;
   logic                    data_next;
   pcimon_msg_t             msg_reg;
   pcimon_msg_t             msg_next;
   logic                    rpt_reg;
   logic                    rpt_next;
   pcimon_msg_t             sts_reg;
   pcimon_msg_t             sts_next;
   logic                    sts_vld_reg;
   logic                    sts_vld_next;
   logic [`PCIMON_SEQ_W-1:0] seq_reg;
   logic [`PCIMON_SEQ_W-1:0] seq_next;
   logic [`PCIMON_CNT_W-1:0] age_reg;
   logic [`PCIMON_CNT_W-1:0] age_next;
   logic                    start_evt;
   logic                    clr_tmr;
   logic                    mab_exp;
   logic                    nor_exp;
   pcimon_msg_t             term;

   ////////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers; the bus lines are treated as foreign pins
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sync1_reg <= 5'h1f;
         sync2_reg <= 5'h1f;
      end else begin
         sync1_reg <= {i_framen, i_irdyn, i_trdyn, i_devseln, i_stopn};
         sync2_reg <= sync1_reg;
      end
   end

   assign frame_a  = ~sync2_reg[4];
   assign irdy_a   = ~sync2_reg[3];
   assign trdy_a   = ~sync2_reg[2];
   assign devsel_a = ~sync2_reg[1];
   assign stop_a   = ~sync2_reg[0];

   ////////////////////////////////////////////////////////////////////////////
   // Stop decoding: abort, retry or one of the two disconnects
   function automatic pcimon_msg_t stop_class(input logic devsel,
                                              input logic trdy,
                                              input logic data);
      if (!devsel)
         return MSG_TABORT;
      else if (trdy)
         return MSG_DISC_A;
      else if (!data)
         return MSG_RETRY;
      else
         return MSG_DISC_B;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Timeouts
   pcimon_timer #(
      .CNT_W     (`PCIMON_CNT_W),
      .LIMIT     (MABORT_CLKS)
   ) u_mabort_tmr (
      .i_core_clk(i_core_clk),
      .i_nrst    (i_nrst),
      .i_start   (start_evt),
      .i_resp    (devsel_a),
      .i_clear   (clr_tmr),
      .o_expired (mab_exp)
   );

   pcimon_timer #(
      .CNT_W     (`PCIMON_CNT_W),
      .LIMIT     (NORESP_CLKS)
   ) u_noresp_tmr (
      .i_core_clk(i_core_clk),
      .i_nrst    (i_nrst),
      .i_start   (start_evt),
      .i_resp    (trdy_a),
      .i_clear   (clr_tmr),
      .o_expired (nor_exp)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Transaction tracking
   always_comb begin
      st_next      = st_reg;
      data_next    = data_reg;
      msg_next     = MSG_NONE;
      rpt_next     = 1'b0;
      sts_next     = sts_reg;
      sts_vld_next = 1'b0;
      seq_next     = seq_reg;
      start_evt    = 1'b0;
      clr_tmr      = 1'b0;
      term         = MSG_NONE;
      // Rising frame only, so a frame still held after an outcome is not taken again
      unique case (st_reg)
         ST_IDLE: begin
            start_evt = frame_a && !fprev_reg;
         end
         ST_BUSY: begin
            if (irdy_a && trdy_a)
               data_next = 1'b1;
            if (mab_exp)
               term = MSG_MABORT;
            else if (stop_a)
               term = stop_class(devsel_a, trdy_a, data_reg);
            else if (nor_exp)
               term = MSG_NORESP;
            else if (!frame_a && irdy_a && trdy_a)
               term = MSG_DONE;
         end
         ST_DRAIN: begin
            if (frame_a && !fprev_reg)
               start_evt = 1'b1;
            else if (!frame_a && !irdy_a)
               st_next = ST_IDLE;
         end
      endcase
      if (term != MSG_NONE) begin
         st_next      = ST_DRAIN;
         msg_next     = term;
         rpt_next     = 1'b1;
         sts_next     = term;
         sts_vld_next = 1'b1;
         clr_tmr      = 1'b1;
      end
      if (start_evt) begin
         st_next   = ST_BUSY;
         data_next = 1'b0;
         msg_next  = MSG_START;
         rpt_next  = 1'b1;
         seq_next  = seq_reg + 1'b1;
      end
      age_next = start_evt ? `PCIMON_AGE_RST :
                 (&age_reg) ? age_reg : age_reg + 1'b1;
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_reg      <= ST_IDLE;
         fprev_reg   <= 1'b0;
         data_reg    <= 1'b0;
         msg_reg     <= MSG_NONE;
         rpt_reg     <= 1'b0;
         sts_reg     <= MSG_NONE;
         sts_vld_reg <= 1'b0;
         seq_reg     <= `PCIMON_SEQ_RST;
         age_reg     <= `PCIMON_AGE_RST;
      end else begin
         st_reg      <= st_next;
         fprev_reg   <= frame_a;
         data_reg    <= data_next;
         msg_reg     <= msg_next;
         rpt_reg     <= rpt_next;
         sts_reg     <= sts_next;
         sts_vld_reg <= sts_vld_next;
         seq_reg     <= seq_next;
         age_reg     <= age_next;
      end
   end

   // Console and log share one register so they can never disagree
   assign o_console_valid     = rpt_reg;
   assign o_console_msg       = msg_reg;
   assign o_log_valid         = rpt_reg;
   assign o_log_msg           = msg_reg;
   assign o_log_seq           = seq_reg;
   assign o_mstr_status_valid = sts_vld_reg;
   assign o_mstr_status       = sts_reg;
   assign o_busy              = st_reg[1];

   ////////////////////////////////////////////////////////////////////////////
   chk_mabort_delay: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      (o_mstr_status_valid && o_mstr_status == MSG_MABORT)
         |-> (age_reg == MABORT_CLKS + 5'h01))
      else $error("master abort reported at wrong cycle");

   chk_noresp_delay: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      (o_mstr_status_valid && o_mstr_status == MSG_NORESP)
         |-> (age_reg == NORESP_CLKS + 5'h01))
      else $error("no-response reported at wrong cycle");

   chk_mabort_fires: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      start_evt ##1 (!devsel_a && !stop_a && !trdy_a) [*4]
         |=> ##1 (o_mstr_status_valid && o_mstr_status == MSG_MABORT))
      else $error("missing master abort");

   chk_retry_class: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      (st_reg == ST_BUSY && !mab_exp && stop_a && devsel_a && !trdy_a && !data_reg)
         |=> (o_mstr_status_valid && o_mstr_status == MSG_RETRY))
      else $error("retry misclassified");

   chk_tabort_class: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      (st_reg == ST_BUSY && !mab_exp && stop_a && !devsel_a)
         |=> (o_mstr_status_valid && o_mstr_status == MSG_TABORT))
      else $error("target abort misclassified");

   chk_disc_kinds: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      (st_reg == ST_BUSY && !mab_exp && stop_a && devsel_a && (trdy_a || data_reg))
         |=> (o_mstr_status == ($past(trdy_a) ? MSG_DISC_A : MSG_DISC_B)))
      else $error("disconnect type wrong");

   chk_status_logged: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      o_mstr_status_valid |-> (o_log_valid && o_log_msg == o_mstr_status
                               && o_console_msg == o_mstr_status))
      else $error("status not reported");

   chk_start_report: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      start_evt |=> (o_log_valid && o_console_valid && o_log_msg == MSG_START
                     && o_log_seq == $past(seq_reg) + 16'h0001))
      else $error("transaction start not reported");

   chk_one_outcome: assert property (
      @(posedge i_core_clk) disable iff (!i_nrst)
      o_mstr_status_valid |=> !o_mstr_status_valid)
      else $error("two outcomes for one transaction");

endmodule

`default_nettype wire

// ===== tb/pcimon_agent_mdl.sv
`timescale 1ns/1ps
`default_nettype none

module pcimon_agent_mdl (
   // Clock
   input  wire logic i_core_clk,
   // Bus lines, active low
   output logic      o_framen,
   output logic      o_irdyn,
   output logic      o_devseln,
   output logic      o_trdyn,
   output logic      o_stopn
);
   // Inactive lines are driven high by the model itself
   initial begin
      o_framen  = 1'b1;
      o_irdyn   = 1'b1;
      o_devseln = 1'b1;
      o_trdyn   = 1'b1;
      o_stopn   = 1'b1;
   end

   function automatic logic act_n(input int c, input int a, input int b);
      return !(c >= a && c <= b);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Each line is low from its first to its last cycle; a window 99..0 never fires
   task automatic run(input int w[10], input int len);
      for (int c = 0; c <= len; c++) begin
         @(negedge i_core_clk);
         o_framen  = act_n(c, w[0], w[1]);
         o_irdyn   = act_n(c, w[2], w[3]);
         o_devseln = act_n(c, w[4], w[5]);
         o_trdyn   = act_n(c, w[6], w[7]);
         o_stopn   = act_n(c, w[8], w[9]);
      end
   endtask
endmodule

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcimon_defs.svh"

module tb;
   import pcimon_pkg::*;

   logic          i_core_clk = 1'b0;
   logic          i_nrst     = 1'b0;
   logic          framen, irdyn, devseln, trdyn, stopn;
   logic          cons_v, log_v, st_v, busy;
   pcimon_msg_t   cons_m, log_m, st_m;
   logic [15:0]   seq;
   logic [31:0]   rng        = 32'h00012779;
   logic [15:0]   nxt_seq    = 16'h0000;
   int            error_cnt  = 0;
   int            tests_run  = 0;
   pcimon_msg_t   rq[$], lq[$], sq[$];

   always #10 i_core_clk = ~i_core_clk;

   pcimon_agent_mdl agent_u (
      .i_core_clk(i_core_clk), .o_framen(framen), .o_irdyn(irdyn),
      .o_devseln(devseln), .o_trdyn(trdyn), .o_stopn(stopn));

   pcimon_top #(
      .MABORT_CLKS(`PCIMON_MABORT_CLKS), .NORESP_CLKS(`PCIMON_NORESP_CLKS)
   ) dut_u (
      .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_framen(framen), .i_irdyn(irdyn),
      .i_trdyn(trdyn), .i_devseln(devseln), .i_stopn(stopn),
      .o_console_valid(cons_v), .o_console_msg(cons_m), .o_log_valid(log_v),
      .o_log_msg(log_m), .o_log_seq(seq), .o_mstr_status_valid(st_v),
      .o_mstr_status(st_m), .o_busy(busy));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   function automatic int unsigned rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   // Timeouts count from the frame edge, so late devsel or trdy decide the outcome
   function automatic pcimon_msg_t exp_out(input int k, input int dd, input int td);
      if (k == 5 || dd > `PCIMON_MABORT_CLKS) return MSG_MABORT;
      if (k == 0 && td > `PCIMON_NORESP_CLKS) return MSG_NORESP;
      case (k)
         1: return MSG_RETRY;
         2: return MSG_TABORT;
         3: return MSG_DISC_A;
         4: return MSG_DISC_B;
         default: return MSG_DONE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Reports are collected at the falling edge, where registered outputs are settled
   always @(negedge i_core_clk) begin
      if (i_nrst) begin
         if (cons_v === 1'b1) rq.push_back(cons_m);
         if (log_v === 1'b1) lq.push_back(log_m);
         if (st_v === 1'b1) sq.push_back(st_m);
         if (log_v === 1'b1 && log_m === MSG_START) begin
            chk(seq, nxt_seq, "seq");
            chk(16'(busy), 16'h0001, "busy");
         end
      end
   end

   // Kinds: 0 done, 1 retry, 2 target abort, 3 disc A, 4 disc B, 5 no devsel
   task automatic xact(input int k, input int dd, input int t, input int gap);
      int          w[10];
      int          n;
      pcimon_msg_t e;
      case (k)
         0: w = '{0, 0, 1, t, dd, t, t, t, 99, 0};
         1: w = '{0, t, 1, t + 1, dd, t + 1, 99, 0, t, t + 1};
         2: w = '{0, t, 1, t + 1, dd, t - 1, 99, 0, t, t + 1};
         3: w = '{0, t, 1, t + 1, dd, t + 1, t, t, t, t + 1};
         4: w = '{0, t + 1, 1, t + 2, dd, t + 2, t, t, t + 1, t + 2};
         default: w = '{0, 0, 1, 6, 99, 0, 99, 0, 99, 0};
      endcase
      e = exp_out(k, dd, t);
      nxt_seq++;
      agent_u.run(w, t + 3);
      n = 0;
      while (sq.size() == 0 && n < 40) begin
         @(negedge i_core_clk);
         n++;
      end
      repeat (gap) @(negedge i_core_clk);
      chk(16'(sq.size()), 16'h0001, "status count");
      chk(16'(sq[0]), 16'(e), "status");
      chk({8'(rq.size()), rq[0], rq[1]}, {8'h02, MSG_START, e}, "console");
      chk({8'(lq.size()), lq[0], lq[1]}, {8'h02, MSG_START, e}, "log");
      chk(16'(busy), 16'h0000, "idle");
      rq.delete();
      lq.delete();
      sq.delete();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int c[6][3];
      int k;
      int d;
      c = '{'{0, 4, 4}, '{0, 5, 6}, '{0, 1, 16}, '{0, 2, 17}, '{5, 0, 6}, '{0, 1, 1}};
      repeat (5) @(negedge i_core_clk);
      i_nrst = 1'b1;
      repeat (3) @(negedge i_core_clk);
      for (int i = 0; i < 6; i++) xact(c[i][0], c[i][1], c[i][2], 1);
      for (int i = 0; i < 80; i++) begin
         if (i == 40) begin
            // Second reset: the transaction count must restart
            i_nrst = 1'b0;
            repeat (3) @(negedge i_core_clk);
            chk(seq, 16'h0000, "reset seq");
            chk({8'h00, 4'(st_m), busy, st_v, cons_v, log_v}, 16'h0000, "reset");
            i_nrst = 1'b1;
            nxt_seq = 16'h0000;
            repeat (3) @(negedge i_core_clk);
         end
         k = rnd() % 5;
         d = 1 + rnd() % 4;
         xact(k, d, (k == 0) ? d + rnd() % (17 - d) : d + 1 + rnd() % 10, 1 + rnd() % 3);
      end
      print_verdict();
   end

   // Watchdog well beyond the expected run of under two thousand cycles
   initial begin
      repeat (20000) @(posedge i_core_clk);
      error_cnt++;
      print_verdict();
   end
endmodule

`default_nettype wire
